// *** core/asb_host.v ***
`timescale 1ns/1ps
`include "asb_regs.vh"
// host side controller for a 4K x 1 asynchronous static memory
module asb_host (
  input wire mclk,
  input wire rst_b,
  input wire reqValid,
  input wire reqWrite,
  input wire [11:0] reqAddr,
  input wire reqData,
  output reg reqReady,
  output reg rspValid,
  output reg rspData,
  output reg selectN,
  output reg strobeN,
  output reg [11:0] cellIndexLines,
  output reg dataIn,
  input wire dataOut
);
  // =============================================
  // sequencer states
  localparam ST_IDLE = 3'h0;
  localparam ST_RSETUP = 3'h1;
  localparam ST_RWAIT = 3'h2;
  localparam ST_WSETUP = 3'h3;
  localparam ST_WPULSE = 3'h4;
  localparam ST_RECOVER = 3'h5;

  // =============================================
  // counter end points
  // worked out wide, then cut to the counter width on purpose
  localparam integer ACC_LAST_N = `ASB_ACCESS_CYC + 2;
  localparam integer WP_LAST_N = `ASB_WPULSE_CYC;
  localparam integer OFF_LAST_N = `ASB_OFF_CYC - 1;
  localparam [3:0] ACC_LAST = ACC_LAST_N[3:0];
  localparam [3:0] WP_LAST = WP_LAST_N[3:0];
  localparam [3:0] OFF_LAST = OFF_LAST_N[3:0];

  // =============================================
  // declarations
  reg [2:0] state;
  reg [3:0] count;
  // next values of every register
  reg [2:0] next_state;
  reg [3:0] next_count;
  reg next_reqReady;
  reg next_rspValid;
  reg next_rspData;
  reg next_selectN;
  reg next_strobeN;
  reg [11:0] next_cellIndexLines;
  reg next_dataIn;
  // synced pin, decoded counter ends and request hand-off
  wire dataSync;
  wire accDone;
  wire pulseDone;
  wire offDone;
  wire reqTaken;

  // =============================================
  // data pin synchroniser
  // memory output reaches us asynchronously
  asb_sync u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .din(dataOut),
    .dout(dataSync)
  );

  // =============================================
  // counter end points and request hand-off
  assign accDone = (count == ACC_LAST);
  assign pulseDone = (count == WP_LAST);
  assign offDone = (count == OFF_LAST);
  assign reqTaken = reqValid && reqReady;

  // =============================================
  // access sequencer, next values
  // address is set up one cycle with both controls high, and never
  // moves while select and strobe are both low
  always @*
  begin
    next_state = state;
    next_count = count;
    next_reqReady = reqReady;
    next_rspValid = 1'b0; // answer is a one-cycle pulse
    next_rspData = rspData;
    next_selectN = selectN;
    next_strobeN = strobeN;
    next_cellIndexLines = cellIndexLines;
    next_dataIn = dataIn;
    case (state)
      ST_IDLE:
      begin
        next_reqReady = 1'b1;
        if (reqTaken)
        begin
          next_reqReady = 1'b0;
          next_cellIndexLines = reqAddr; // one cell per access
          next_dataIn = reqData;
          next_count = 4'h0;
          next_state = reqWrite ? ST_WSETUP : ST_RSETUP;
        end
      end
      ST_RSETUP:
      begin
        // address stable before select falls, strobe held high
        next_selectN = 1'b0;
        next_strobeN = 1'b1;
        next_state = ST_RWAIT;
      end
      ST_RWAIT:
      begin
        // access time, one spare cycle, two sync cycles
        // the spare cycle keeps the first sync flop off the data edge
        next_count = count + 4'h1;
        if (accDone)
        begin
          next_rspData = dataSync;
          next_rspValid = 1'b1;
          next_selectN = 1'b1;
          next_count = 4'h0;
          next_state = ST_RECOVER;
        end
      end
      ST_WSETUP:
      begin
        // strobe falls first so the output never turns on
        next_strobeN = 1'b0;
        next_state = ST_WPULSE;
      end
      ST_WPULSE:
      begin
        // write starts at select fall, the later edge
        // select stays low for the whole pulse count
        next_selectN = 1'b0;
        next_count = count + 4'h1;
        if (pulseDone)
        begin
          // select-ended write, data and address held past it
          next_selectN = 1'b1;
          next_count = 4'h0;
          next_state = ST_RECOVER;
        end
      end
      ST_RECOVER:
      begin
        // strobe rises after select; spacing lets output float off
        next_strobeN = 1'b1;
        next_count = count + 4'h1;
        if (offDone)
        begin
          next_count = 4'h0;
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
        next_selectN = 1'b1;
        next_strobeN = 1'b1;
      end
    endcase
  end

  // =============================================
  // sequencer state registers
  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
      count <= 4'h0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
    end
  end

  // =============================================
  // request port registers; ready stays low through reset
  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspData <= 1'b0;
    end
    else
    begin
      reqReady <= next_reqReady;
      rspValid <= next_rspValid;
      rspData <= next_rspData;
    end
  end

  // =============================================
  // memory pin registers
  // pins leave flops so no decode glitch reaches the memory
  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      selectN <= 1'b1; // deselected standby
      strobeN <= 1'b1;
      cellIndexLines <= 12'h000;
      dataIn <= 1'b0;
    end
    else
    begin
      selectN <= next_selectN;
      strobeN <= next_strobeN;
      cellIndexLines <= next_cellIndexLines;
      dataIn <= next_dataIn;
    end
  end
endmodule // asb_host

// *** core/asb_regs.vh ***
`ifndef ASB_REGS_VH
`define ASB_REGS_VH
// =============================================
// widths
`define ASB_ADDR_W 12
// =============================================
// timing, ns at 5 ns clock period
`define ASB_CLK_NS 5
`define ASB_ACCESS_NS 45
`define ASB_WPULSE_NS 25
`define ASB_DSETUP_NS 20
`define ASB_ASETUP_NS 0
`define ASB_OFF_NS 20
// least times round up to whole cycles
`define ASB_ACCESS_CYC ((`ASB_ACCESS_NS + `ASB_CLK_NS - 1) / `ASB_CLK_NS)
`define ASB_WPULSE_CYC ((`ASB_WPULSE_NS + `ASB_CLK_NS - 1) / `ASB_CLK_NS)
`define ASB_DSETUP_CYC ((`ASB_DSETUP_NS + `ASB_CLK_NS - 1) / `ASB_CLK_NS)
`define ASB_OFF_CYC ((`ASB_OFF_NS + `ASB_CLK_NS - 1) / `ASB_CLK_NS)
`define ASB_CNT_W 4
`endif

// *** core/asb_sync.v ***
`timescale 1ns/1ps
// two-flop synchroniser for the memory's data output pin
module asb_sync (
  input wire mclk,
  input wire rst_b,
  input wire din,
  output reg dout
);
  reg stage;
  // =============================================
  // sync chain; stage feeds only dout
  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      stage <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      stage <= din;
      dout <= stage;
    end
  end
endmodule // asb_sync

// *** bench/asb_mem_model.sv ***
`timescale 1ns/1ps
// =====
// 4K x 1 static cell array
module asb_mem_model (
  input wire selectN,
  input wire strobeN,
  input wire [11:0] cellIndexLines,
  input wire dataIn,
  output reg dataOut = 1'b0
);
  reg cells [0:4095];
  reg wrMode = 1'b0;
  realtime tChg = 0.0;
  // write mode comes from whichever control fell last
  always @(negedge selectN) wrMode = !strobeN;
  always @(negedge strobeN) if (!selectN) wrMode = 1'b1;
  // first control to rise closes the write
  always @(posedge selectN or posedge strobeN)
  begin
    if (wrMode) cells[cellIndexLines] = dataIn;
    wrMode = 1'b0;
  end
  always @(selectN or cellIndexLines or wrMode) tChg = $realtime;
  // floating pin wanders so stale bits never pass; valid only after 45 ns access
  always #1 dataOut = (!selectN && strobeN && !wrMode && $realtime - tChg >= 45.0) ?
    cells[cellIndexLines] : ~dataOut;
endmodule // asb_mem_model

// *** bench/asb_host_properties.sv ***
`timescale 1ns/1ps
// =====
// memory pin checker
module asb_host_properties (
  input wire mclk,
  input wire rst_b,
  input wire selectN,
  input wire strobeN,
  input wire [11:0] cellIndexLines,
  input wire dataIn
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_addr_held: assert property (!selectN && !strobeN |-> $stable(cellIndexLines))
    else $error("address moved in write");
  a_data_held: assert property (!selectN && !strobeN |-> $stable(dataIn))
    else $error("data moved in write");
  a_strobe_first: assert property ($fell(strobeN) |-> selectN)
    else $error("strobe fell while selected");
  a_select_ends: assert property ($rose(strobeN) |-> selectN)
    else $error("strobe rose while selected");
  a_read_strobe: assert property ($fell(selectN) && strobeN |-> strobeN [*8])
    else $error("strobe fell in read");
  a_write_width: assert property ($fell(selectN) && !strobeN |-> !selectN [*5] ##1 selectN)
    else $error("write select width wrong");
endmodule // asb_host_properties
bind asb_host asb_host_properties chk (.*);

// *** bench/testbench.sv ***
`timescale 1ns/1ps
// =====
// memory host bench
module testbench;
  reg mclk = 1'b0, rst_b = 1'b0, reqValid = 1'b0, reqWrite = 1'b0, reqData = 1'b0;
  reg [11:0] reqAddr = 12'h000;
  wire reqReady, rspValid, rspData, selectN, strobeN, dataIn, dataOut;
  wire [11:0] cellIndexLines;
  integer mismatches = 0, total_checks = 0, i, n;
  asb_host uut (.*);
  asb_mem_model mem (.*);
  initial forever #2.5 mclk = ~mclk;
  task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("ERROR %0s exp %0h got %0h", nm, exp, got);
    end
  end
  endtask
  // one request held until taken; a read is judged on its answer
  task send(input w, input [11:0] a, input d);
  begin
    @(posedge mclk) #1;
    {reqValid, reqWrite, reqAddr, reqData} = {1'b1, w, a, d};
    while (reqReady !== 1'b1) @(posedge mclk) #1;
    @(posedge mclk) #1;
    reqValid = 1'b0;
    for (n = 0; !w && rspValid !== 1'b1 && n < 40; n = n + 1) @(posedge mclk) #1;
    // select cycle, 9 access, 1 spare, 2 sync
    if (!w) chk("latency", 13, n);
    if (!w) chk("rspData", d, rspData);
  end
  endtask
  // cells 000, 555, AAA and FFF back to back, read back in reverse
  task tPatterns;
  begin
    for (i = 0; i < 4; i = i + 1) send(1'b1, 12'h555 * i[1:0], i[0] ^ i[1]);
    for (i = 3; i >= 0; i = i - 1) send(1'b0, 12'h555 * i[1:0], i[0] ^ i[1]);
  end
  endtask
  // rewriting cell 555 leaves cell AAA alone
  task tOverwrite;
  begin
    send(1'b1, 12'h555, 1'b0);
    send(1'b0, 12'h555, 1'b0);
    send(1'b0, 12'hAAA, 1'b1);
  end
  endtask
  task results;
  begin
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  // =====
  // main sequence
  initial
  begin
    repeat (3) @(posedge mclk);
    #1 rst_b = 1'b1;
    tPatterns;
    tOverwrite;
    results;
  end
  // hang guard, well past the expected run
  initial
  begin
    #20000;
    mismatches = mismatches + 1;
    results;
  end
endmodule // testbench
